// ==== hw/rcb_pkg.sv ====
// Purpose: Shared constants for the receive control byte engine.
// Assumes: 25 MHz system clock, 16 lines, 16-bit receive words.
// Notes:   Receive word fields, command and progress bits, codes, word and byte reset values, line, depth and timeout counts live here.
`default_nettype none
package rcb_pkg;
    localparam int WORD_W = 16;
    localparam int FIFO_DEPTH = 4;
    localparam int LINES = 16;
    localparam int CLK_MHZ = 25;
    localparam int NXM_TIMEOUT_US = 20;
    localparam int NXM_CYCLES = NXM_TIMEOUT_US * CLK_MHZ;
    localparam int TMR_W = 10;
    // Receive word fields
    localparam int W_CHAR_LO = 0;
    localparam int W_LINE_LO = 8;
    localparam int W_PARITY = 12;
    localparam int W_OVERRUN = 13;
    localparam int W_RESYNC = 15;
    // Control byte command bits
    localparam int CB_INT = 0;
    localparam int CB_EXPECT = 2;
    localparam int CB_INCLUDE = 3;
    localparam int CB_DISCARD = 4;
    localparam int CB_MODE_LO = 5;
    localparam logic [7:0] CB_DISCARD_ONLY = 8'h10;
    localparam logic [7:0] CB_MSG_MODE = 8'h08;
    localparam logic [7:0] CB_KEEP_MASK = 8'he0;
    // Line progress bits
    localparam int PR_FIRST_CHECK_CHAR = 5;
    localparam int PR_SECOND_CHECK_CHAR = 6;
    localparam int PR_RESYNC = 7;
    // Interrupt character codes in bits 12-15
    localparam logic [3:0] IC_BCC_DONE = 4'h5;
    localparam logic [3:0] IC_BC_ZERO_IN = 4'h8;
    localparam logic [3:0] IC_BC_ZERO_OUT = 4'h4;
    localparam logic [3:0] IC_NXM = 4'hc;
    localparam logic [3:0] IC_MPE = 4'hd;
    // Check type bit that asks for two check characters
    localparam int CT_TWO = 1;
    localparam logic [15:0] CRC_POLY = 16'ha001;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0] RST_BYTE = 8'h00;

    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_TEST = 5'b00010,
        S_FETCH = 5'b00100,
        S_ACT = 5'b01000,
        S_STORE = 5'b10000
    } state_e;
endpackage
`default_nettype wire

// ==== hw/word_fifo.sv ====
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: Depth is a power of two.
// Notes:   Head word stays put until the drain side takes it.
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;

    assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign out_data = mem_q[rd_q[AW-1:0]];
    assign push = ce && in_valid && in_ready;
    assign pop = ce && out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== hw/receive_control_byte_engine.sv ====
// Purpose: Per-character receive control for a multiline communications
//          multiplexer: screening, control byte fetch and action.
// Assumes: Host memory answers dma requests with ack, data or parity error.
// Notes:   Per-line storage is held in arrays indexed by line number.
// What this block does
// - A character at the fifo head leaves idle and starts processing.
// - Fetched byte kept per line; interrupt bit cleared after it interrupts.
// - Error or block end stores a discard-only control byte.
// - Head word copied to result; stays in fifo; bits 8-11 pick line.
// - Normal case fetches the control byte by dma read.
// - Exceptional conditions are handled without a fetch, then idle.
// - Parity or overrun: report character, discard-only byte, interrupt.
// - Resync expected and no resync flag: discard character.
// - Resync expected and flag found: discard and clear expectation.
// - Zero byte count: report with bit 15, discard-only, interrupt.
// - First check character accumulated; two-char type expects a second.
// - Full check ORs both bytes into report, sets bits 12 and 14.
// - After check report, control byte gets discard, low bits cleared.
// - Message mode with mode 000 skips fetch and accumulates.
// - Address is base plus mode bits at 8-10 plus character.
// - Missing memory and memory parity errors go to error handling.
// - No memory answer within 20 us is a missing memory error.
// - Fetched byte stored; its bits 5-7 become the next mode.
// - Commands taken as interrupt, expect, include, discard.
// - Interrupt bit reports the character and raises the flag.
// - Expect bit marks the next character as first check character.
// - Include bit folds the character into the line's check.
// - Discard bit pops the fifo without storing.
// - Neither interrupt nor discard stores by dma write at line address.
// - Flag holds off processing; host response clears it and resumes.
`default_nettype none
module receive_control_byte_engine (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [15:0] rx_word,
    input wire logic [15:0] ctrl_table_base,
    input wire logic [1:0] check_type,
    input wire logic message_protocol_receive_mode,
    input wire logic cfg_we,
    input wire logic [3:0] cfg_line,
    input wire logic [15:0] cfg_byte_count,
    input wire logic [15:0] cfg_cur_addr,
    input wire logic [2:0] cfg_mode,
    input wire logic cfg_resync,
    input wire logic [3:0] rd_line,
    output logic [7:0] hold_byte,
    output logic [15:0] receive_interrupt_character_reg,
    output logic receiver_interrupt_flag,
    input wire logic interrupt_response_bit,
    output logic dma_bus_request,
    output logic dma_write,
    output logic [15:0] dma_addr,
    output logic [7:0] dma_wdata,
    input wire logic dma_ack,
    input wire logic [7:0] dma_read_data_reg,
    input wire logic memory_parity_error
);
    ////////////////////////////////////////////////////////////////////
    // Reset release and storage
    logic rst_s1_b;
    logic rst_n;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_b <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_b <= 1'b1;
            rst_n <= rst_s1_b;
        end
    end

    rcb_pkg::state_e state_q;
    logic [15:0] result_q;
    logic [7:0] cb_q;
    logic reentry_q;
    logic pop_q;
    logic [rcb_pkg::TMR_W-1:0] tmr_q;
    logic [7:0] prog_q [rcb_pkg::LINES];
    logic [2:0] mode_q [rcb_pkg::LINES];
    logic [15:0] bcount_q [rcb_pkg::LINES];
    logic [15:0] caddr_q [rcb_pkg::LINES];
    logic [15:0] bcc_q [rcb_pkg::LINES];
    logic [7:0] hold_q [rcb_pkg::LINES];

    logic fifo_valid;
    logic [15:0] fifo_word;
    logic [3:0] ln;
    logic [7:0] ch;
    logic two_chars;
    logic [15:0] bcc_new;
    logic [15:0] bc_inc;

    // Head stays put until an explicit pop, so error paths can still read it
    word_fifo #(.WIDTH(rcb_pkg::WORD_W), .DEPTH(rcb_pkg::FIFO_DEPTH)) u_fifo (
        .clk(sys_clk),
        .rst_n(rst_n),
        .ce(ce),
        .in_valid(rx_valid),
        .in_ready(rx_ready),
        .in_data(rx_word),
        .out_valid(fifo_valid),
        .out_ready(pop_q),
        .out_data(fifo_word)
    );

    ////////////////////////////////////////////////////////////////////
    // Check accumulation
    function automatic logic [15:0] fold(input logic [15:0] acc,
                                         input logic [7:0] c,
                                         input logic two);
        logic [15:0] r;
        r = acc ^ {8'h00, c};
        if (two) begin
            for (int i = 0; i < 8; i++) begin
                r = r[0] ? ((r >> 1) ^ rcb_pkg::CRC_POLY) : (r >> 1);
            end
        end else begin
            r = {8'h00, r[7:0]};
        end
        return r;
    endfunction

    assign ln = result_q[rcb_pkg::W_LINE_LO +: 4];
    assign ch = result_q[rcb_pkg::W_CHAR_LO +: 8];
    assign two_chars = check_type[rcb_pkg::CT_TWO];
    assign bcc_new = fold(bcc_q[ln], ch, two_chars);
    assign bc_inc = bcount_q[ln] + 16'h0001;

    ////////////////////////////////////////////////////////////////////
    // Sequencer and per-line storage
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= rcb_pkg::S_IDLE;
            result_q <= rcb_pkg::RST_WORD;
            cb_q <= rcb_pkg::RST_BYTE;
            reentry_q <= 1'b0;
            pop_q <= 1'b0;
            tmr_q <= '0;
            receiver_interrupt_flag <= 1'b0;
            receive_interrupt_character_reg <= rcb_pkg::RST_WORD;
            dma_bus_request <= 1'b0;
            dma_write <= 1'b0;
            dma_addr <= rcb_pkg::RST_WORD;
            dma_wdata <= rcb_pkg::RST_BYTE;
            hold_byte <= rcb_pkg::RST_BYTE;
            for (int i = 0; i < rcb_pkg::LINES; i++) begin
                prog_q[i] <= rcb_pkg::RST_BYTE;
                mode_q[i] <= 3'h0;
                bcount_q[i] <= rcb_pkg::RST_WORD;
                caddr_q[i] <= rcb_pkg::RST_WORD;
                bcc_q[i] <= rcb_pkg::RST_WORD;
                hold_q[i] <= rcb_pkg::RST_BYTE;
            end
        end else if (ce) begin
            pop_q <= 1'b0;
            hold_byte <= hold_q[rd_line];
            if (cfg_we) begin
                bcount_q[cfg_line] <= cfg_byte_count;
                caddr_q[cfg_line] <= cfg_cur_addr;
                mode_q[cfg_line] <= cfg_mode;
                prog_q[cfg_line][rcb_pkg::PR_RESYNC] <= cfg_resync;
            end
            // Flag only rises with the sequencer heading idle, so no clash
            if (receiver_interrupt_flag && interrupt_response_bit) begin
                receiver_interrupt_flag <= 1'b0;
                reentry_q <= 1'b1;
            end
            case (state_q)
                rcb_pkg::S_IDLE: begin
                    // Wait out a pop issued last cycle before sampling head
                    if (fifo_valid && !pop_q && !receiver_interrupt_flag) begin
                        result_q <= fifo_word;
                        state_q <= rcb_pkg::S_TEST;
                    end
                end
                rcb_pkg::S_TEST: begin
                    state_q <= rcb_pkg::S_IDLE;
                    if (reentry_q) begin
                        reentry_q <= 1'b0;
                        cb_q <= hold_q[ln];
                        state_q <= rcb_pkg::S_ACT;
                    end else if (result_q[rcb_pkg::W_PARITY] ||
                                 result_q[rcb_pkg::W_OVERRUN]) begin
                        receive_interrupt_character_reg <= result_q;
                        hold_q[ln] <= rcb_pkg::CB_DISCARD_ONLY;
                        receiver_interrupt_flag <= 1'b1;
                    end else if (prog_q[ln][rcb_pkg::PR_RESYNC]) begin
                        pop_q <= 1'b1;
                        if (result_q[rcb_pkg::W_RESYNC]) begin
                            prog_q[ln][rcb_pkg::PR_RESYNC] <= 1'b0;
                        end
                    end else if (bcount_q[ln][14:0] == 15'h0000) begin
                        receive_interrupt_character_reg <=
                            {rcb_pkg::IC_BC_ZERO_IN, result_q[11:0]};
                        hold_q[ln] <= rcb_pkg::CB_DISCARD_ONLY;
                        receiver_interrupt_flag <= 1'b1;
                    end else if (prog_q[ln][rcb_pkg::PR_SECOND_CHECK_CHAR] ||
                                 (prog_q[ln][rcb_pkg::PR_FIRST_CHECK_CHAR] &&
                                  !two_chars)) begin
                        // Check character stays at head; reentry discards it
                        prog_q[ln][rcb_pkg::PR_SECOND_CHECK_CHAR] <= 1'b0;
                        prog_q[ln][rcb_pkg::PR_FIRST_CHECK_CHAR] <= 1'b0;
                        bcc_q[ln] <= bcc_new;
                        receive_interrupt_character_reg <=
                            {rcb_pkg::IC_BCC_DONE, 4'h0,
                             bcc_new[15:8] | bcc_new[7:0]};
                        hold_q[ln] <= (hold_q[ln] & rcb_pkg::CB_KEEP_MASK) |
                                      rcb_pkg::CB_DISCARD_ONLY;
                        receiver_interrupt_flag <= 1'b1;
                    end else if (prog_q[ln][rcb_pkg::PR_FIRST_CHECK_CHAR]) begin
                        prog_q[ln][rcb_pkg::PR_FIRST_CHECK_CHAR] <= 1'b0;
                        prog_q[ln][rcb_pkg::PR_SECOND_CHECK_CHAR] <= 1'b1;
                        bcc_q[ln] <= bcc_new;
                        pop_q <= 1'b1;
                    end else if (message_protocol_receive_mode &&
                                 mode_q[ln] == 3'h0) begin
                        cb_q <= rcb_pkg::CB_MSG_MODE;
                        state_q <= rcb_pkg::S_ACT;
                    end else begin
                        dma_addr <= ctrl_table_base +
                                    {5'h00, mode_q[ln], 8'h00} +
                                    {8'h00, ch};
                        dma_bus_request <= 1'b1;
                        dma_write <= 1'b0;
                        tmr_q <= '0;
                        state_q <= rcb_pkg::S_FETCH;
                    end
                end
                rcb_pkg::S_FETCH: begin
                    tmr_q <= tmr_q + 1'b1;
                    if (dma_ack) begin
                        dma_bus_request <= 1'b0;
                        if (memory_parity_error) begin
                            receive_interrupt_character_reg <=
                                {rcb_pkg::IC_MPE, result_q[11:0]};
                            hold_q[ln] <= rcb_pkg::CB_DISCARD_ONLY;
                            receiver_interrupt_flag <= 1'b1;
                            state_q <= rcb_pkg::S_IDLE;
                        end else begin
                            cb_q <= dma_read_data_reg;
                            hold_q[ln] <= dma_read_data_reg;
                            mode_q[ln] <=
                                dma_read_data_reg[rcb_pkg::CB_MODE_LO +: 3];
                            state_q <= rcb_pkg::S_ACT;
                        end
                    end else if (tmr_q ==
                                 rcb_pkg::TMR_W'(rcb_pkg::NXM_CYCLES - 1)) begin
                        dma_bus_request <= 1'b0;
                        receive_interrupt_character_reg <=
                            {rcb_pkg::IC_NXM, result_q[11:0]};
                        hold_q[ln] <= rcb_pkg::CB_DISCARD_ONLY;
                        receiver_interrupt_flag <= 1'b1;
                        state_q <= rcb_pkg::S_IDLE;
                    end
                end
                rcb_pkg::S_ACT: begin
                    state_q <= rcb_pkg::S_IDLE;
                    if (cb_q[rcb_pkg::CB_INT]) begin
                        // Later commands run on reentry, from the cleared copy
                        receive_interrupt_character_reg <= result_q;
                        receiver_interrupt_flag <= 1'b1;
                        hold_q[ln] <= cb_q &
                                      ~(8'h01 << rcb_pkg::CB_INT);
                    end else begin
                        if (cb_q[rcb_pkg::CB_EXPECT]) begin
                            prog_q[ln][rcb_pkg::PR_FIRST_CHECK_CHAR] <= 1'b1;
                        end
                        if (cb_q[rcb_pkg::CB_INCLUDE]) begin
                            bcc_q[ln] <= bcc_new;
                        end
                        if (cb_q[rcb_pkg::CB_DISCARD]) begin
                            pop_q <= 1'b1;
                        end else begin
                            dma_addr <= caddr_q[ln];
                            dma_wdata <= ch;
                            dma_write <= 1'b1;
                            dma_bus_request <= 1'b1;
                            tmr_q <= '0;
                            state_q <= rcb_pkg::S_STORE;
                        end
                    end
                end
                rcb_pkg::S_STORE: begin
                    tmr_q <= tmr_q + 1'b1;
                    if (dma_ack) begin
                        dma_bus_request <= 1'b0;
                        dma_write <= 1'b0;
                        // Count at zero keeps the char so reentry drops it
                        pop_q <= bc_inc[14:0] != 15'h0000;
                        caddr_q[ln] <= caddr_q[ln] + 16'h0001;
                        bcount_q[ln] <= bc_inc;
                        if (bc_inc[14:0] == 15'h0000) begin
                            receive_interrupt_character_reg <=
                                {rcb_pkg::IC_BC_ZERO_OUT, result_q[11:0]};
                            hold_q[ln] <= rcb_pkg::CB_DISCARD_ONLY;
                            receiver_interrupt_flag <= 1'b1;
                        end
                        state_q <= rcb_pkg::S_IDLE;
                    end else if (tmr_q ==
                                 rcb_pkg::TMR_W'(rcb_pkg::NXM_CYCLES - 1)) begin
                        dma_bus_request <= 1'b0;
                        dma_write <= 1'b0;
                        receive_interrupt_character_reg <=
                            {rcb_pkg::IC_NXM, result_q[11:0]};
                        hold_q[ln] <= rcb_pkg::CB_DISCARD_ONLY;
                        receiver_interrupt_flag <= 1'b1;
                        state_q <= rcb_pkg::S_IDLE;
                    end
                end
                default: begin
                    state_q <= rcb_pkg::S_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_idle_entry: assert property (state_q == rcb_pkg::S_IDLE && ce &&
        fifo_valid && !pop_q && !receiver_interrupt_flag |=>
        state_q == rcb_pkg::S_TEST)
        else $error("head character not taken");
    a_flag_idle: assert property (receiver_interrupt_flag |->
        state_q == rcb_pkg::S_IDLE)
        else $error("processing while flag set");
    a_flag_level: assert property (receiver_interrupt_flag &&
        !interrupt_response_bit |=>
        receiver_interrupt_flag)
        else $error("flag dropped without response");
    a_ack_resume: assert property (receiver_interrupt_flag &&
        interrupt_response_bit && ce |=>
        !receiver_interrupt_flag && reentry_q)
        else $error("response did not clear flag");
    a_error_report: assert property (state_q == rcb_pkg::S_TEST &&
        ce && !reentry_q &&
        (result_q[12] || result_q[13]) |=> receiver_interrupt_flag &&
        receive_interrupt_character_reg == $past(result_q))
        else $error("parity or overrun not reported");
    a_nxm_bound: assert property (dma_bus_request |->
        tmr_q < rcb_pkg::TMR_W'(rcb_pkg::NXM_CYCLES))
        else $error("memory wait ran past timeout");
    a_discard_pop: assert property (state_q == rcb_pkg::S_ACT && ce &&
        !cb_q[0] && cb_q[4] |=>
        pop_q ##1 !pop_q)
        else $error("discard did not pop once");
    a_store_write: assert property (state_q == rcb_pkg::S_ACT && ce &&
        !cb_q[0] && !cb_q[4] |=>
        dma_bus_request && dma_write && dma_wdata == $past(result_q[7:0]))
        else $error("store write not issued");
    a_fetch_act: assert property (state_q == rcb_pkg::S_FETCH && ce &&
        dma_ack &&
        !memory_parity_error |=> state_q == rcb_pkg::S_ACT &&
        cb_q == $past(dma_read_data_reg))
        else $error("fetched byte not acted on");
endmodule
`default_nettype wire

// ==== bench/host_mem_model.sv ====
// Purpose: Host memory answering the engine's byte-wide dma cycles.
// Assumes: One access outstanding; request held until after the ack.
// Notes:   Alternates prompt and slow answers; idle data lines wander.
`default_nettype none
module host_mem_model (
    input wire logic sys_clk,
    input wire logic dma_bus_request,
    input wire logic dma_write,
    input wire logic [15:0] dma_addr,
    input wire logic [7:0] cb,
    input wire logic no_answer,
    input wire logic bad_parity,
    output logic dma_ack,
    output logic [7:0] dma_read_data_reg,
    output logic memory_parity_error,
    output logic [15:0] last_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt = 4'h0;
    logic slow = 1'b0;
    initial begin
        dma_ack = 1'b0;
        dma_read_data_reg = 8'h00;
        memory_parity_error = 1'b0;
        last_addr = 16'h0000;
    end
    // Data lines toggle when idle so a stale byte is never trusted
    always @(posedge sys_clk) begin
        dma_ack <= 1'b0;
        memory_parity_error <= 1'b0;
        dma_read_data_reg <= ~dma_read_data_reg;
        cnt <= dma_bus_request ? cnt + 4'h1 : 4'h0;
        if (dma_bus_request && !dma_ack && !no_answer &&
            cnt == (slow ? 4'h7 : 4'h0)) begin
            dma_ack <= 1'b1;
            slow <= ~slow;
            dma_read_data_reg <= cb;
            memory_parity_error <= bad_parity && !dma_write;
            if (!dma_write)
                last_addr <= dma_addr;
        end
    end
endmodule
`default_nettype wire

// ==== bench/tb_receive_control_byte_engine.sv ====
// Purpose: Self-checking bench for the receive control byte engine.
// Assumes: One character in flight at a time, so the fifo never fills.
// Notes:   Characters, lines and bytes from a fixed xorshift seed.
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb_receive_control_byte_engine;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0, rst_b = 1'b0, ce = 1'b1, rx_valid = 1'b0;
    logic rx_ready, receiver_interrupt_flag, interrupt_response_bit = 1'b0;
    logic message_protocol_receive_mode = 1'b0, cfg_we = 1'b0;
    logic cfg_resync = 1'b0, no_answer = 1'b0, bad_parity = 1'b0;
    logic dma_bus_request, dma_write, dma_ack, memory_parity_error;
    logic [1:0] check_type = 2'h0;
    logic [2:0] cfg_mode = 3'h0;
    logic [3:0] cfg_line = 4'h0, rd_line = 4'h0;
    logic [7:0] hold_byte, dma_wdata, dma_read_data_reg, cb = 8'h00;
    logic [15:0] rx_word = 16'h0000, ctrl_table_base = 16'h0000, w, e;
    logic [15:0] cfg_byte_count = 16'h0000, cfg_cur_addr = 16'h0000;
    logic [15:0] receive_interrupt_character_reg, dma_addr, last_addr;
    logic [31:0] seed = 32'h0000_0001, r;
    int num_errors = 0, compares = 0;
    receive_control_byte_engine uut (.sys_clk, .rst_b, .ce, .rx_valid,
        .rx_ready, .rx_word, .ctrl_table_base, .check_type,
        .message_protocol_receive_mode, .cfg_we, .cfg_line,
        .cfg_byte_count, .cfg_cur_addr, .cfg_mode, .cfg_resync, .rd_line,
        .hold_byte, .receive_interrupt_character_reg,
        .receiver_interrupt_flag, .interrupt_response_bit,
        .dma_bus_request, .dma_write, .dma_addr, .dma_wdata, .dma_ack,
        .dma_read_data_reg, .memory_parity_error);
    host_mem_model mem (.sys_clk, .dma_bus_request, .dma_write, .dma_addr,
        .cb, .no_answer, .bad_parity, .dma_ack, .dma_read_data_reg,
        .memory_parity_error, .last_addr);
    always #20 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] coded(logic [3:0] c, logic [15:0] v);
        return {c, v[11:0]};
    endfunction
    task automatic cfg(logic [15:0] cnt, logic rs);
        @(posedge sys_clk);
        cfg_we <= 1'b1;
        cfg_line <= w[11:8];
        cfg_byte_count <= cnt;
        cfg_mode <= r[10:8];
        cfg_resync <= rs;
        cfg_cur_addr <= r[31:16];
        @(posedge sys_clk);
        cfg_we <= 1'b0;
    endtask
    task automatic send(logic [15:0] v);
        @(posedge sys_clk);
        rx_valid <= 1'b1;
        rx_word <= v;
        rd_line <= v[11:8];
        @(posedge sys_clk);
        rx_valid <= 1'b0;
    endtask
    // Bounded wait; the no-answer timeout needs about 500 cycles
    task automatic await(logic exp);
        for (int i = 0; i < 700; i++) begin
            @(posedge sys_clk);
            #1;
            if (receiver_interrupt_flag === 1'b1)
                break;
        end
        `CHK(receiver_interrupt_flag, exp)
    endtask
    task automatic respond();
        @(posedge sys_clk);
        interrupt_response_bit <= 1'b1;
        @(posedge sys_clk);
        interrupt_response_bit <= 1'b0;
        #1;
        `CHK(receiver_interrupt_flag, 1'b0)
        repeat (40) @(posedge sys_clk);
        #1;
    endtask
    task automatic wrap_up();
        $display("Comparisons %0d, errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #(40 * 80000);
        num_errors++;
        wrap_up();
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge sys_clk);
        for (int k = 0; k < 6; k++) begin
            r = xs();
            w = {4'h0, r[7:4], r[15:8]};
            cb = {r[18:16], 5'h01};
            ctrl_table_base <= {r[27:24], 12'h000};
            check_type <= r[21:20];
            cfg(16'h0010, 1'b1);
            send(w);
            await(1'b0);
            send(w | 16'h8000);
            await(1'b0);
            send(w);
            await(1'b1);
            e = ctrl_table_base + {5'h00, cfg_mode, 8'h00} + {8'h00, w[7:0]};
            `CHK(last_addr, e)
            `CHK(receive_interrupt_character_reg, w)
            respond();
            `CHK(hold_byte, cb & 8'hfe)
            `CHK(dma_addr, r[31:16])
            `CHK(dma_wdata, w[7:0])
            w[7:0] = r[23:16] ^ 8'h5a;
            e = ctrl_table_base + {5'h00, cb[7:5], 8'h00} + {8'h00, w[7:0]};
            send(w);
            await(1'b1);
            `CHK(last_addr, e)
            respond();
            `CHK(dma_addr, r[31:16] + 16'h0001)
            `CHK(dma_wdata, w[7:0])
            send(w | 16'h1000 << k[0]);
            await(1'b1);
            `CHK(receive_interrupt_character_reg, w | 16'h1000 << k[0])
            respond();
            `CHK(hold_byte, 8'h10)
            cfg(16'h8000, 1'b0);
            send(w);
            await(1'b1);
            `CHK(receive_interrupt_character_reg, coded(4'h8, w))
            respond();
            cfg(16'h0020, 1'b0);
            no_answer <= k[0];
            bad_parity <= !k[0];
            send(w);
            await(1'b1);
            e = coded(k[0] ? 4'hc : 4'hd, w);
            `CHK(receive_interrupt_character_reg, e)
            no_answer <= 1'b0;
            bad_parity <= 1'b0;
            respond();
            r[10:8] = 3'h0;
            cfg(16'h0020, 1'b0);
            message_protocol_receive_mode <= 1'b1;
            send(w);
            await(1'b0);
            `CHK(dma_addr, r[31:16])
            `CHK(dma_wdata, w[7:0])
            message_protocol_receive_mode <= 1'b0;
        end
        wrap_up();
    end
endmodule
`default_nettype wire
